// ===== bench/tb.sv
`timescale 1ns/10ps
module tb;
    reg         pclk;
    reg         presetn;
    reg         psel;
    reg         penable;
    reg         pwrite;
    reg  [11:0] paddr;
    reg  [31:0] pwdata;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire        s_valid;
    wire        s_ready;
    wire [15:0] s_i;
    wire [15:0] s_q;
    wire [15:0] dac_i;
    wire [15:0] dac_q;
    wire [1:0]  interp_sel;
    reg  [15:0] i_val;       // Source I value
    reg  [15:0] q_val;       // Source Q value
    reg  [31:0] rd;          // Last read word
    reg         err;         // Last error flag
    reg  [15:0] b;           // Pass-through reference
    reg  [15:0] c;           // Scratch sum
    reg  [15:0] si [0:7];    // Captured I words
    reg  [15:0] sq [0:7];    // Captured Q words
    reg  [15:0] d  [0:3];    // Data words between midscales
    integer     fail_count = 0;
    integer     checks_done = 0;
    integer     m;
    integer     j;
    zscm_core #(.W(16)) zscm_core_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .s_valid(s_valid), .s_i(s_i), .s_q(s_q),
        .s_ready(s_ready), .dac_i(dac_i), .dac_q(dac_q),
        .interp_sel(interp_sel));
    zscm_source zscm_source_i (.pclk(pclk), .presetn(presetn),
        .s_ready(s_ready), .i_val(i_val), .q_val(q_val),
        .s_valid(s_valid), .s_i(s_i), .s_q(s_q));
    // Verdict and end of run
    task summarize;
    begin
        if (fail_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    // Compare one value
    task chk(input [31:0] got, input [31:0] exp);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    // One APB transfer, waits for pready
    task apb(input w, input [11:0] ad, input [31:0] wd);
    begin
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    end
    endtask
    // Write control, let the pipe settle, capture eight words
    task run(input [7:0] v);
    begin
        apb(1'b1, 12'h004, {24'h0, v});
        repeat (10) @(posedge pclk);
        for (j = 0; j < 8; j = j + 1)
        begin
            @(posedge pclk);
            si[j] = dac_i;
            sq[j] = dac_q;
        end
    end
    endtask
    // Register map, interpolation field and refused accesses
    task t_regs;
    begin
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0);
        for (m = 0; m < 4; m = m + 1)
        begin
            apb(1'b1, 12'h004, 32'hffffff00 | (m << 6));
            apb(1'b0, 12'h004, 32'h0);
            chk(rd, m << 6);
            chk(interp_sel, m);
        end
        apb(1'b1, 12'h008, 32'h0);
        chk(err, 1'b1);
        apb(1'b0, 12'h00c, 32'h0);
        chk(err, 1'b1);
        apb(1'b0, 12'h008, 32'h0);
        chk(err, 1'b0);
        chk(rd[31:4], 28'h0);
    end
    endtask
    // Pass-through, then stuffing of the same stream
    task t_stuff;
    begin
        run(8'h00);
        c = si[0];
        i_val <= 16'h1334;
        run(8'h00);
        b = si[0];
        chk(b - c, 16'h0100);
        run(8'h08);
        chk((si[0] == 16'h8000) ^ (si[1] == 16'h8000), 1'b1);
        c = si[0] + si[1] - 16'h8000;
        chk(c, b);
        run(8'h28);
        for (j = 0; j < 4; j = j + 1)
        begin
            chk((si[2*j] == 16'h8000) ^ (si[2*j+1] == 16'h8000), 1'b1);
            d[j] = si[2*j] + si[2*j+1] - 16'h8000;
        end
        chk(d[0] !== d[1], 1'b1);
        c = d[0] + d[2] + 16'h1;
        chk(c < 16'h3, 1'b1);
        c = d[1] + d[3] + 16'h1;
        chk(c < 16'h3, 1'b1);
    end
    endtask
    // Real half, quarter and eighth rate, then complex signs
    task t_mod;
    begin
        for (m = 1; m < 4; m = m + 1)
        begin
            run(m << 4);
            chk(si[0] !== si[1], 1'b1);
            for (j = 0; j < (1 << (m - 1)); j = j + 1)
            begin
                c = si[j] + si[j + (1 << (m - 1))] + 16'h1;
                chk(c < 16'h3, 1'b1);
            end
        end
        q_val <= 16'h0000;
        run(8'h24);
        c = sq[1] - si[0] + 16'h1;
        chk(c < 16'h3, 1'b1);
        run(8'h26);
        c = sq[1] + si[0] + 16'h1;
        chk(c < 16'h3, 1'b1);
    end
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Timeout guard
    initial
    begin
        #300000;
        fail_count = fail_count + 1;
        summarize;
    end
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        i_val = 16'h1234;
        q_val = 16'h4321;
        repeat (12) @(posedge pclk);
        chk({dac_i, dac_q}, 32'h8000_8000);
        chk({s_ready, interp_sel}, 32'h0);
        presetn <= 1'b1;
        t_regs;
        t_stuff;
        t_mod;
        summarize;
    end
endmodule

// ===== bench/zscm_core_assertions.sv
`timescale 1ns/10ps
// Port checker for the modulator core
module zscm_chk (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        pslverr,
    input wire        s_ready,
    input wire [15:0] dac_i,
    input wire [1:0]  interp_sel
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire       acc = psel && penable && pready; // Completed access
    wire       wr  = acc && pwrite && paddr == 12'h004; // Control write
    reg  [1:0] isel_reg;  // Last interpolation code written
    reg        zs_reg;    // Last stuffing bit written
    reg  [3:0] cnt_reg;   // Cycles since the last control write
    // Track the control word so steady modes can be recognised
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            isel_reg <= 2'h0;
            zs_reg   <= 1'b0;
            cnt_reg  <= 4'h0;
        end
        else if (wr)
        begin
            isel_reg <= pwdata[7:6];
            zs_reg   <= pwdata[3];
            cnt_reg  <= 4'h0;
        end
        else if (cnt_reg != 4'hf)
            cnt_reg <= cnt_reg + 4'h1;
    wire steady = cnt_reg > 4'h7; // Mode change has flushed through
    interp_set_a: assert property (wr |-> ##[1:2] interp_sel == isel_reg)
        else $error("interp_sel does not follow write");
    interp_hold_a: assert property (interp_sel != $past(interp_sel)
        |-> $past(wr) || $past(wr, 2)) else $error("interp_sel moved alone");
    access_wait_a: assert property (psel && !penable |=> pready)
        else $error("pready late");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    bad_addr_a: assert property (acc && paddr != 12'h004 &&
        (pwrite || paddr != 12'h008) |-> pslverr) else $error("no pslverr");
    half_rate_a: assert property (zs_reg && steady && s_ready |=>
        !s_ready) else $error("stuffing input rate wrong");
    full_rate_a: assert property (!zs_reg && steady && s_ready |=>
        s_ready) else $error("input stalled without stuffing");
    midscale_a: assert property (zs_reg && steady && dac_i != 16'h8000
        |=> dac_i == 16'h8000) else $error("midscale missing");
    cover property (wr && pwdata[3]);
    cover property (acc && pslverr);
    cover property (zs_reg && steady && s_ready);
endmodule

bind zscm_core zscm_chk zscm_chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .s_ready(s_ready), .dac_i(dac_i), .interp_sel(interp_sel));

// ===== bench/zscm_source.sv
`timescale 1ns/10ps
// Upstream sample source: holds each I/Q pair until it is taken
module zscm_source (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        s_ready,
    input  wire [15:0] i_val,
    input  wire [15:0] q_val,
    output reg         s_valid,
    output reg  [15:0] s_i,
    output reg  [15:0] s_q
);
    // Offer a fresh pair once the last one was taken; pacing by s_ready
    // halves to one pair every second clock when stuffing is on
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            s_valid <= 1'b0;
            s_i     <= 16'h0;
            s_q     <= 16'h0;
        end
        else if (!s_valid || s_ready)
        begin
            s_valid <= 1'b1;
            s_i     <= i_val;
            s_q     <= q_val;
        end
endmodule

// ===== inc/zscm_defines.vh
`ifndef ZSCM_DEFINES_VH
`define ZSCM_DEFINES_VH

// APB register byte offsets
`define ZSCM_ADDR_CTRL      12'h004
`define ZSCM_ADDR_STATUS    12'h008

// Control register field positions
`define ZSCM_INTERP_HI      7
`define ZSCM_INTERP_LO      6
`define ZSCM_MODF_HI        5
`define ZSCM_MODF_LO        4
`define ZSCM_ZSTUFF_BIT     3
`define ZSCM_CPLX_BIT       2
`define ZSCM_CSIGN_BIT      1

// Control register reset value
`define ZSCM_CTRL_RESET     8'h00

// Modulation frequency codes
`define ZSCM_MOD_OFF        2'b00
`define ZSCM_MOD_HALF       2'b01
`define ZSCM_MOD_QUARTER    2'b10
`define ZSCM_MOD_EIGHTH     2'b11

// Midscale code inserted by zero stuffing
`define ZSCM_MIDSCALE       16'h8000

// 0.707 in Q1.15
`define ZSCM_COS45          16'h5a82

`endif

// ===== rtl/zscm_core.v
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "zscm_defines.vh"

module zscm_core
#(
    parameter W = 16
)
(
    input  wire          pclk,
    input  wire          presetn,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [11:0]   paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output reg           pready,
    output reg           pslverr,
    input  wire          s_valid,
    input  wire [W-1:0]  s_i,
    input  wire [W-1:0]  s_q,
    output reg           s_ready,
    output reg  [W-1:0]  dac_i,
    output reg  [W-1:0]  dac_q,
    output reg  [1:0]    interp_sel
);

    // ----------------------------------------------------------------
    // Registers and state
    // ----------------------------------------------------------------
    reg  [7:0]   ctrl_reg;          // Control register
    reg  [2:0]   ph_reg;            // Carrier phase, eighths of a turn
    reg          mod_valid_reg;     // Modulator output valid
    reg  [W-1:0] mi_reg;            // Modulated I
    reg  [W-1:0] mq_reg;            // Modulated Q
    reg  [W-1:0] mi_next;
    reg  [W-1:0] mq_next;
    reg  signed [W-1:0] cos_c;      // Carrier cosine
    reg  signed [W-1:0] sin_c;      // Carrier sine
    reg  signed [W-1:0] real_c;     // Carrier for real modulation
    reg  [2:0]   php;               // Phase snapped onto the carrier grid
    reg  [2:0]   step;              // Phase step per sample
    wire         rdy_i;             // Stuffer ready, I lane
    wire         rdy_q;             // Stuffer ready, Q lane
    wire [W-1:0] z_i;               // Stuffer output, I lane
    wire [W-1:0] z_q;               // Stuffer output, Q lane
    wire         take;              // Sample accepted
    wire         apb_wr;
    wire         apb_rd;

    wire [1:0] modf  = ctrl_reg[`ZSCM_MODF_HI:`ZSCM_MODF_LO];
    wire       zst   = ctrl_reg[`ZSCM_ZSTUFF_BIT];
    wire       cplx  = ctrl_reg[`ZSCM_CPLX_BIT];
    wire       csign = ctrl_reg[`ZSCM_CSIGN_BIT];

    assign take   = s_valid && s_ready;
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !pwrite;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Carrier value at phase p (eighths): cos45 scaled, else +/-1 or 0
    function signed [W-1:0] carrier;
        input [2:0] p;
        begin
            case (p)
                3'd0: carrier = {1'b0, {(W-1){1'b1}}};
                3'd1: carrier = `ZSCM_COS45;
                3'd2: carrier = {W{1'b0}};
                3'd3: carrier = -`ZSCM_COS45;
                3'd4: carrier = {1'b1, {(W-1){1'b0}}} + 1'b1;
                3'd5: carrier = -`ZSCM_COS45;
                3'd6: carrier = {W{1'b0}};
                default: carrier = `ZSCM_COS45;
            endcase
        end
    endfunction

    // Q1.15 product, truncated back to W bits
    function signed [W-1:0] qmul;
        input signed [W-1:0] a;
        input signed [W-1:0] b;
        reg   signed [2*W-1:0] p;
        begin
            p    = a * b;
            qmul = p[2*W-2:W-1];
        end
    endfunction

    // ----------------------------------------------------------------
    // APB slave: zero wait states, unmapped address errors
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= `ZSCM_CTRL_RESET;
            prdata   <= 32'h0000_0000;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && paddr != `ZSCM_ADDR_CTRL
                       && !(paddr == `ZSCM_ADDR_STATUS && !pwrite);
            if (apb_wr && pready && paddr == `ZSCM_ADDR_CTRL)
                ctrl_reg <= pwdata[7:0];
            if (apb_rd && !penable)
            begin
                if (paddr == `ZSCM_ADDR_CTRL)
                    prdata <= {24'h000000, ctrl_reg};
                else if (paddr == `ZSCM_ADDR_STATUS)
                    prdata <= {28'h0000000, mod_valid_reg,
                               ph_reg};
                else
                    prdata <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // Carrier selection
    // ----------------------------------------------------------------
    always @*
    begin
        // Half rate steps 4, quarter 2, eighth 1 eighths a sample
        case (modf)
            `ZSCM_MOD_HALF:    step = 3'd4;
            `ZSCM_MOD_QUARTER: step = 3'd2;
            `ZSCM_MOD_EIGHTH:  step = 3'd1;
            default:           step = 3'd0;
        endcase
        // Snap the phase onto the grid of the selected rate, so a rate
        // change never leaves the carrier between its points
        php   = ph_reg & ~(step - 3'd1);
        cos_c = carrier(php);
        sin_c = carrier(php - 3'd2);
        // Half rate has no sine term: it alternates +1 and -1
        if (modf == `ZSCM_MOD_HALF)
            real_c = cos_c;
        else
            real_c = sin_c;
        if (csign)
            sin_c = -sin_c;
    end

    // ----------------------------------------------------------------
    // Modulator datapath
    // ----------------------------------------------------------------
    always @*
    begin
        if (modf == `ZSCM_MOD_OFF)
        begin
            mi_next = s_i;
            mq_next = s_q;
        end
        else if (cplx && modf != `ZSCM_MOD_HALF)
        begin
            // Complex product of (I + jQ) and carrier
            mi_next = qmul(s_i, cos_c) - qmul(s_q, sin_c);
            mq_next = qmul(s_i, sin_c) + qmul(s_q, cos_c);
        end
        else
        begin
            // Real modulation, the carrier sign plays no part
            mi_next = qmul(s_i, real_c);
            mq_next = qmul(s_q, real_c);
        end
    end

    // Modulator register; stalls while the stuffer is busy
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ph_reg        <= 3'd0;
            mod_valid_reg <= 1'b0;
            mi_reg        <= {W{1'b0}};
            mq_reg        <= {W{1'b0}};
            s_ready       <= 1'b0;
        end
        else
        begin
            s_ready <= rdy_i && rdy_q && !(take && zst);
            if (take)
            begin
                mi_reg        <= mi_next;
                mq_reg        <= mq_next;
                ph_reg        <= ph_reg + step;
                mod_valid_reg <= 1'b1;
            end
            else if (rdy_i)
                mod_valid_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Zero stuffing after modulator, ahead of converter
    // ----------------------------------------------------------------
    zscm_stuffer #(.W(W)) u_stuff_i
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .enable   (zst),
        .in_valid (mod_valid_reg),
        .in_data  (mi_reg),
        .in_ready (rdy_i),
        .out_data (z_i)
    );

    zscm_stuffer #(.W(W)) u_stuff_q
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .enable   (zst),
        .in_valid (mod_valid_reg),
        .in_data  (mq_reg),
        .in_ready (rdy_q),
        .out_data (z_q)
    );

    // ----------------------------------------------------------------
    // Converter outputs and interpolation setting
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dac_i      <= `ZSCM_MIDSCALE;
            dac_q      <= `ZSCM_MIDSCALE;
            interp_sel <= 2'b00;
        end
        else
        begin
            dac_i      <= z_i;
            dac_q      <= z_q;
            interp_sel <= ctrl_reg[`ZSCM_INTERP_HI:`ZSCM_INTERP_LO];
        end
    end

endmodule

// ===== rtl/zscm_stuffer.v
`timescale 1ns/10ps
`include "zscm_defines.vh"

// Zero-stuffing stage: after every modulator sample, one midscale sample
module zscm_stuffer
#(
    parameter W = 16
)
(
    input  wire         pclk,
    input  wire         presetn,
    input  wire         enable,
    input  wire         in_valid,
    input  wire [W-1:0] in_data,
    output reg          in_ready,
    output reg  [W-1:0] out_data
);

    reg         phase_reg;      // 1 while the midscale slot is due
    reg [W-1:0] data_reg;       // Output word

    // ----------------------------------------------------------------
    // Sample and midscale interleave
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_reg <= 1'b0;
            data_reg  <= `ZSCM_MIDSCALE;
            in_ready  <= 1'b1;
        end
        else if (!enable)
        begin
            // Pass-through, one sample per clock
            phase_reg <= 1'b0;
            in_ready  <= 1'b1;
            if (in_valid)
                data_reg <= in_data;
        end
        else if (phase_reg)
        begin
            // Midscale slot doubles the output rate
            data_reg  <= `ZSCM_MIDSCALE;
            phase_reg <= 1'b0;
            in_ready  <= 1'b1;
        end
        else if (in_valid)
        begin
            // Data slot, midscale follows next cycle
            data_reg  <= in_data;
            phase_reg <= 1'b1;
            in_ready  <= 1'b0;
        end
    end

    always @*
        out_data = data_reg;

endmodule
